// ==== include/cardbus_pkg.sv ====
// Shared constants and types for the card socket clock, reset and AD link.
// Assumes both socket ends and the joining interface import this package.
package cardbus_pkg;

  // Multiplexed address/data bus, line 31 most significant
  localparam int AD_WIDTH = 32;
  localparam int AD_MSB = 31;

  // Socket clock half periods in host clock cycles
  localparam logic [7:0] NORMAL_HALF = 8'h01;
  localparam logic [7:0] SLOW_HALF = 8'h08;

  // Socket clock rises spent announcing a slow-down, and the settle guard
  localparam logic [2:0] ANNOUNCE_CLOCKS = 3'h4;
  localparam logic [2:0] ANNOUNCE_GUARD = 3'h2;

  // Card-side register bank
  localparam int CARD_REGS = 4;
  localparam int CARD_IDX_W = 2;
  localparam int CARD_IDX_LSB = 2;

  // AD value driven in reset (the host floats AD when idle), and the clock-run pull level
  localparam logic [AD_WIDTH-1:0] AD_IDLE = 32'h0000_0000;
  localparam logic CLKRUN_PULL = 1'h0;

  typedef enum logic [1:0] {PWR_NORMAL, PWR_SLOW, PWR_STOP} power_mode_t;

  function automatic logic [CARD_IDX_W-1:0] reg_index(input logic [AD_WIDTH-1:0] addr);
    reg_index = addr[CARD_IDX_LSB +: CARD_IDX_W];
  endfunction : reg_index

endpackage : cardbus_pkg

// ==== include/cardbus_if.sv ====
// Socket link between the host controller end and the card end.
// Assumes pull-ups on the open-drain clock-run line and on the AD lines.
`timescale 1ns/1ns
interface cardbus_if;
  import cardbus_pkg::*;

  logic socket_clock_out;
  logic socket_card_reset_b;
  logic addr_phase;
  logic write_phase;
  logic run_host_out;
  logic run_host_oe;
  logic run_card_out;
  logic run_card_oe;
  logic socket_clock_run;
  logic [AD_WIDTH-1:0] ad_host_out;
  logic ad_host_oe;
  logic [AD_WIDTH-1:0] ad_card_out;
  logic ad_card_oe;
  logic [AD_WIDTH-1:0] socket_addr_data;

  // Wired level: any driver pulling clock-run low wins; AD takes the host, then the card; else pulled high
  assign socket_clock_run = ~((run_host_oe & ~run_host_out) | (run_card_oe & ~run_card_out));
  assign socket_addr_data = ad_host_oe ? ad_host_out : (ad_card_oe ? ad_card_out : '1);

  modport host (
    output socket_clock_out, socket_card_reset_b, addr_phase, write_phase,
    output run_host_out, run_host_oe, ad_host_out, ad_host_oe,
    input socket_clock_run, socket_addr_data
  );

  modport card (
    input socket_clock_out, socket_card_reset_b, addr_phase, write_phase,
    output run_card_out, run_card_oe, ad_card_out, ad_card_oe,
    input socket_clock_run, socket_addr_data
  );

endinterface : cardbus_if

// ==== verilog/cardbus_host_end.sv ====
// Host controller end: makes the socket clock, runs clock-run negotiation,
// drives the card reset and performs single-word AD transfers.
// Assumes i_clk is the host bus clock domain; all user inputs are on it.
//
// Overview of operation
// - Socket signals sampled on socket clock rising edge; the host end samples them on i_clk through two flip-flops.
// - Socket clock normally runs at host bus rate; here at half the i_clk rate, one cycle per half period.
// - Clock may slow or stop; stopped means low.
// - Card requests faster clock via clock-run line.
// - Announce clock decrease on clock-run before slowing.
// - Card reset returns card logic to known state.
// - In reset card floats, controller holds valid levels; the card model floats AD only, its clock-run drive follows i_clock_request.
// - Reset asserts anytime, releases with socket clock.
// - Address phase carries full 32-bit address.
// - Data phases carry data word on same lines.
// - Line 31 is the most significant bit.
`timescale 1ns/1ns
module cardbus_host_end
  import cardbus_pkg::*;
#(
  parameter logic [7:0] NORMAL_HALF_P = NORMAL_HALF,
  parameter logic [7:0] SLOW_HALF_P = SLOW_HALF
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  cardbus_if.host link,
  input wire power_mode_t i_power_mode,
  input wire logic i_card_reset,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [AD_WIDTH-1:0] i_addr,
  input wire logic [AD_WIDTH-1:0] i_wdata,
  output logic o_ack,
  output logic [AD_WIDTH-1:0] o_rdata,
  output logic o_clock_full
);

  typedef enum logic [1:0] {CK_RUN, CK_ANNOUNCE, CK_LOW} clock_state_t;
  typedef enum logic [2:0] {X_IDLE, X_ADDR, X_WDATA, X_RD1, X_RD2, X_GAP} xfer_state_t;

  clock_state_t ck_reg;
  clock_state_t ck_next;
  xfer_state_t x_reg;
  logic [7:0] half_cnt_reg;
  logic [7:0] half_lim;
  logic sock_clk_reg;
  logic hold_low;
  logic toggle;
  logic rise_tick;
  logic fall_tick;
  logic [2:0] ann_cnt_reg;
  logic run_oe_reg;
  logic [1:0] run_sync_reg;
  logic [AD_WIDTH-1:0] ad_sync1_reg;
  logic [AD_WIDTH-1:0] ad_sync2_reg;
  logic card_rst_b_reg;
  logic [1:0] rel_sync_reg;
  logic [AD_WIDTH-1:0] ad_out_reg;
  logic ad_oe_reg;
  logic addr_phase_reg;
  logic write_reg;
  logic ack_reg;
  logic [AD_WIDTH-1:0] rdata_reg;
  logic full_reg;

  // Pin inputs through two flip-flops
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      run_sync_reg <= 2'h3;
      ad_sync1_reg <= '0;
      ad_sync2_reg <= '0;
    end
    else
    begin
      run_sync_reg <= {run_sync_reg[0], link.socket_clock_run};
      ad_sync1_reg <= link.socket_addr_data;
      ad_sync2_reg <= ad_sync1_reg;
    end
  end

  // Divider: half period by state, frozen low when stopped
  always_comb
  begin
    half_lim = (ck_reg == CK_LOW && i_power_mode == PWR_SLOW) ? SLOW_HALF_P : NORMAL_HALF_P;
    hold_low = (ck_reg == CK_LOW) && (i_power_mode == PWR_STOP) && !sock_clk_reg;
    toggle = !hold_low && (half_cnt_reg >= half_lim - 8'h01);
    rise_tick = toggle && !sock_clk_reg;
    fall_tick = toggle && sock_clk_reg;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      half_cnt_reg <= 8'h00;
      sock_clk_reg <= 1'h0;
    end
    else
    begin
      half_cnt_reg <= (toggle || hold_low) ? 8'h00 : half_cnt_reg + 8'h01;
      if (toggle)
        sock_clk_reg <= !sock_clk_reg;
    end
  end

  // Clock-run negotiation
  always_comb
  begin
    ck_next = ck_reg;
    unique case (ck_reg)
      CK_RUN:
        if (i_power_mode != PWR_NORMAL && x_reg == X_IDLE && !i_req && card_rst_b_reg)
          ck_next = CK_ANNOUNCE;
      CK_ANNOUNCE:
        if (i_power_mode == PWR_NORMAL || i_req || i_card_reset)
          ck_next = CK_RUN;
        else if (ann_cnt_reg >= ANNOUNCE_GUARD && !run_sync_reg[1])
          ck_next = CK_RUN;
        else if (rise_tick && ann_cnt_reg == ANNOUNCE_CLOCKS - 3'h1)
          ck_next = CK_LOW;
      CK_LOW:
        if (i_power_mode == PWR_NORMAL || i_req || !run_sync_reg[1] || !card_rst_b_reg)
          ck_next = CK_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ck_reg <= CK_RUN;
      ann_cnt_reg <= 3'h0;
      run_oe_reg <= 1'h1;
      full_reg <= 1'h1;
    end
    else
    begin
      ck_reg <= ck_next;
      if (ck_next != CK_ANNOUNCE)
        ann_cnt_reg <= 3'h0;
      else if (rise_tick)
        ann_cnt_reg <= ann_cnt_reg + 3'h1;
      run_oe_reg <= (ck_next == CK_RUN);
      full_reg <= (ck_next == CK_RUN);
    end
  end

  // Card reset: asserted at once, released on a socket clock fall
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rel_sync_reg <= 2'h0;
      card_rst_b_reg <= 1'h0;
    end
    else if (i_card_reset)
    begin
      rel_sync_reg <= 2'h0;
      card_rst_b_reg <= 1'h0;
    end
    else
    begin
      if (rise_tick)
        rel_sync_reg <= {rel_sync_reg[0], 1'h1};
      if (fall_tick && rel_sync_reg[1])
        card_rst_b_reg <= 1'h1;
    end
  end

  // Transfers, stepped on socket clock falls so the card samples mid-period
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      x_reg <= X_IDLE;
      ad_out_reg <= AD_IDLE;
      ad_oe_reg <= 1'h1;
      addr_phase_reg <= 1'h0;
      write_reg <= 1'h0;
      ack_reg <= 1'h0;
      rdata_reg <= '0;
    end
    else
    begin
      ack_reg <= 1'h0;
      if (!card_rst_b_reg)
      begin
        x_reg <= X_IDLE;
        ad_out_reg <= AD_IDLE;
        ad_oe_reg <= 1'h1;
        addr_phase_reg <= 1'h0;
      end
      else if (fall_tick)
      begin
        unique case (x_reg)
          X_IDLE:
            if (i_req && ck_reg == CK_RUN)
            begin
              ad_out_reg <= i_addr;
              ad_oe_reg <= 1'h1;
              addr_phase_reg <= 1'h1;
              write_reg <= i_write;
              x_reg <= X_ADDR;
            end
            else
              ad_oe_reg <= 1'h0;
          X_ADDR:
          begin
            addr_phase_reg <= 1'h0;
            ad_out_reg <= i_wdata;
            ad_oe_reg <= write_reg;
            x_reg <= write_reg ? X_WDATA : X_RD1;
          end
          X_WDATA:
          begin
            ad_oe_reg <= 1'h0;
            ack_reg <= 1'h1;
            x_reg <= X_GAP;
          end
          X_RD1:
            x_reg <= X_RD2;
          X_RD2:
          begin
            rdata_reg <= ad_sync2_reg;
            ack_reg <= 1'h1;
            x_reg <= X_GAP;
          end
          X_GAP:
            x_reg <= X_IDLE;
        endcase
      end
    end
  end

  assign link.socket_clock_out = sock_clk_reg;
  assign link.socket_card_reset_b = card_rst_b_reg;
  assign link.run_host_out = CLKRUN_PULL;
  assign link.run_host_oe = run_oe_reg;
  assign link.ad_host_out = ad_out_reg;
  assign link.ad_host_oe = ad_oe_reg;
  assign link.addr_phase = addr_phase_reg;
  assign link.write_phase = write_reg;
  assign o_ack = ack_reg;
  assign o_rdata = rdata_reg;
  assign o_clock_full = full_reg;

endmodule : cardbus_host_end

// ==== verilog/cardbus_card_end.sv ====
// Card end: a small register bank answering AD transfers on the socket
// clock, plus a clock-run request and write reports in the i_clk domain.
// Assumes the socket clock and card reset come from the host end.
`timescale 1ns/1ns
module cardbus_card_end
  import cardbus_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  cardbus_if.card link,
  input wire logic i_clock_request,
  output logic o_write_valid,
  output logic [AD_WIDTH-1:0] o_write_addr,
  output logic [AD_WIDTH-1:0] o_write_data,
  output logic o_card_in_reset
);

  typedef enum logic [2:0] {C_IDLE, C_WR, C_TURN, C_DRIVE, C_HOLD} card_state_t;

  card_state_t c_reg;
  logic [AD_WIDTH-1:0] bank_reg [CARD_REGS];
  logic [AD_WIDTH-1:0] addr_reg;
  logic [AD_WIDTH-1:0] ad_out_reg;
  logic ad_oe_reg;
  logic [AD_WIDTH-1:0] wr_addr_reg;
  logic [AD_WIDTH-1:0] wr_data_reg;
  logic wr_tog_reg;
  logic [2:0] tog_sync_reg;
  logic [1:0] rst_sync_reg;
  logic run_oe_reg;
  logic write_valid_reg;
  logic [AD_WIDTH-1:0] write_addr_reg;
  logic [AD_WIDTH-1:0] write_data_reg;
  logic in_reset_reg;
  logic wr_seen;

  // Socket clock domain, cleared by the card reset
  always_ff @(posedge link.socket_clock_out or negedge link.socket_card_reset_b)
  begin
    if (!link.socket_card_reset_b)
    begin
      c_reg <= C_IDLE;
      for (int i = 0; i < CARD_REGS; i++)
        bank_reg[i] <= '0;
      addr_reg <= '0;
      ad_out_reg <= AD_IDLE;
      ad_oe_reg <= 1'h0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_tog_reg <= 1'h0;
    end
    else
    begin
      unique case (c_reg)
        C_IDLE:
          if (link.addr_phase)
          begin
            addr_reg <= link.socket_addr_data;
            c_reg <= link.write_phase ? C_WR : C_TURN;
          end
        C_WR:
        begin
          bank_reg[reg_index(addr_reg)] <= link.socket_addr_data;
          wr_addr_reg <= addr_reg;
          wr_data_reg <= link.socket_addr_data;
          wr_tog_reg <= !wr_tog_reg;
          c_reg <= C_IDLE;
        end
        C_TURN:
        begin
          ad_out_reg <= bank_reg[reg_index(addr_reg)];
          ad_oe_reg <= 1'h1;
          c_reg <= C_DRIVE;
        end
        C_DRIVE:
          c_reg <= C_HOLD;
        C_HOLD:
        begin
          ad_oe_reg <= 1'h0;
          c_reg <= C_IDLE;
        end
        default:
          c_reg <= C_IDLE;
      endcase
    end
  end

  // Host-side reports: toggle crossing for writes, level crossing for reset
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tog_sync_reg <= 3'h0;
      rst_sync_reg <= 2'h0;
      run_oe_reg <= 1'h0;
      write_valid_reg <= 1'h0;
      write_addr_reg <= '0;
      write_data_reg <= '0;
      in_reset_reg <= 1'h1;
    end
    else
    begin
      tog_sync_reg <= {tog_sync_reg[1:0], wr_tog_reg};
      rst_sync_reg <= {rst_sync_reg[0], link.socket_card_reset_b};
      in_reset_reg <= !rst_sync_reg[1];
      run_oe_reg <= i_clock_request;
      write_valid_reg <= wr_seen;
      if (wr_seen)
      begin
        write_addr_reg <= wr_addr_reg;
        write_data_reg <= wr_data_reg;
      end
    end
  end

  // Toggle cleared by card reset is not a write
  assign wr_seen = (tog_sync_reg[2] ^ tog_sync_reg[1]) && rst_sync_reg[1];

  assign link.run_card_out = CLKRUN_PULL;
  assign link.run_card_oe = run_oe_reg;
  assign link.ad_card_out = ad_out_reg;
  assign link.ad_card_oe = ad_oe_reg;
  assign o_write_valid = write_valid_reg;
  assign o_write_addr = write_addr_reg;
  assign o_write_data = write_data_reg;
  assign o_card_in_reset = in_reset_reg;

endmodule : cardbus_card_end

// ==== test/cardbus_link_sva.sv ====
// Concurrent checks on the socket link joining the host and card ends.
// Assumes i_clk is the host clock from which the socket clock is divided.
`timescale 1ns/1ns
module cardbus_link_sva
  import cardbus_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_card_reset,
  input wire logic socket_clock_out,
  input wire logic socket_card_reset_b,
  input wire logic addr_phase,
  input wire logic write_phase,
  input wire logic run_host_oe,
  input wire logic ad_host_oe,
  input wire logic ad_card_oe,
  input wire logic [AD_WIDTH-1:0] socket_addr_data
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_clock_stops_low: assert property ($rose(socket_clock_out) |-> ##[1:8] !socket_clock_out)
    else $error("socket clock held high too long");
  a_full_rate_kept: assert property ((run_host_oe && $changed(socket_clock_out)) ##1 run_host_oe
    |-> $changed(socket_clock_out))
    else $error("socket clock slowed while in full run");
  a_announce_first: assert property ($fell(run_host_oe) |-> $changed(socket_clock_out)[*6])
    else $error("socket clock slowed without announcement");
  a_reset_any_time: assert property (i_card_reset |=> !socket_card_reset_b)
    else $error("card reset not asserted at once");
  a_release_on_fall: assert property ($rose(socket_card_reset_b) |-> $fell(socket_clock_out))
    else $error("card reset released off the socket clock");
  a_release_synced: assert property ($rose(socket_card_reset_b) |-> !$past(socket_card_reset_b, 3))
    else $error("card reset release skipped the synchronizer");
  a_reset_levels: assert property (!socket_card_reset_b && $past(!socket_card_reset_b)
    |-> ad_host_oe && !ad_card_oe && socket_addr_data == AD_IDLE)
    else $error("AD lines not held at valid levels in card reset");
  a_address_phase: assert property ($rose(addr_phase) |-> ad_host_oe ##1 (addr_phase && ad_host_oe)
    ##1 !addr_phase)
    else $error("address phase not one socket clock");
  a_write_data: assert property ($fell(addr_phase) && write_phase && socket_card_reset_b
    |-> ad_host_oe ##1 ad_host_oe ##1 (!ad_host_oe || !socket_card_reset_b))
    else $error("write data phase malformed");
  a_read_turn: assert property ($fell(addr_phase) && !write_phase && socket_card_reset_b
    |-> !ad_host_oe ##[1:4] (ad_card_oe || !socket_card_reset_b))
    else $error("card did not drive read data");
endmodule : cardbus_link_sva

// ==== test/testbench.sv ====
// Testbench joining the host and card socket ends through the link interface.
// Assumes the package and interface are compiled ahead of this file.
`timescale 1ns/1ns
module testbench
  import cardbus_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_rst_b = 1'h0;
  power_mode_t i_power_mode = PWR_NORMAL;
  logic i_card_reset = 1'h0;
  logic i_req = 1'h0;
  logic i_write = 1'h0;
  logic [AD_WIDTH-1:0] i_addr = '0;
  logic [AD_WIDTH-1:0] i_wdata = '0;
  logic i_clock_request = 1'h0;
  logic o_ack, o_clock_full, o_write_valid, o_card_in_reset;
  logic [AD_WIDTH-1:0] o_rdata, o_write_addr, o_write_data, rd, len;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  cardbus_if link_if();
  cardbus_host_end cardbus_host_end_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link_if),
    .i_power_mode(i_power_mode), .i_card_reset(i_card_reset), .i_req(i_req), .i_write(i_write),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_ack(o_ack), .o_rdata(o_rdata),
    .o_clock_full(o_clock_full));
  cardbus_card_end cardbus_card_end_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link_if),
    .i_clock_request(i_clock_request), .o_write_valid(o_write_valid),
    .o_write_addr(o_write_addr), .o_write_data(o_write_data), .o_card_in_reset(o_card_in_reset));
  cardbus_link_sva cardbus_link_sva_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_card_reset(i_card_reset), .socket_clock_out(link_if.socket_clock_out),
    .socket_card_reset_b(link_if.socket_card_reset_b), .addr_phase(link_if.addr_phase),
    .write_phase(link_if.write_phase), .run_host_oe(link_if.run_host_oe),
    .ad_host_oe(link_if.ad_host_oe), .ad_card_oe(link_if.ad_card_oe),
    .socket_addr_data(link_if.socket_addr_data));

  always #5 i_clk = ~i_clk;

  task automatic check(input logic [AD_WIDTH-1:0] seen, input logic [AD_WIDTH-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // One transfer, request held until the ack edge
  task automatic xfer(input logic wr, input logic [AD_WIDTH-1:0] a, input logic [AD_WIDTH-1:0] d);
    bit seen_addr;
    seen_addr = 1'b0;
    i_req = 1'h1;
    i_write = wr;
    i_addr = a;
    i_wdata = d;
    for (n = 0; n < 200 && o_ack !== 1'h1; n++)
    begin
      @(posedge i_clk);
      if (link_if.addr_phase === 1'h1 && !seen_addr)
      begin
        seen_addr = 1'b1;
        check(link_if.socket_addr_data, a);
      end
    end
    check(32'(o_ack), 32'h1);
    rd = o_rdata;
    #1;
    i_req = 1'h0;
    tick(1);
  endtask : xfer

  task automatic write_word(input logic [AD_WIDTH-1:0] a, input logic [AD_WIDTH-1:0] d);
    xfer(1'h1, a, d);
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (n < 40 && o_write_valid !== 1'h1);
    check(32'(o_write_valid), 32'h1);
    check(o_write_addr, a);
    check(o_write_data, d);
    #1;
  endtask : write_word

  // Cycles the socket clock stays low in one half period
  task automatic half_len();
    len = '0;
    for (n = 0; n < 40 && link_if.socket_clock_out !== 1'h1; n++)
      @(posedge i_clk);
    for (n = 0; n < 40 && link_if.socket_clock_out !== 1'h0; n++)
      @(posedge i_clk);
    for (n = 0; n < 40 && link_if.socket_clock_out !== 1'h1; n++)
    begin
      @(posedge i_clk);
      len++;
    end
    #1;
  endtask : half_len

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    tick(2);
    i_rst_b = 1'h1;
    tick(12);
    check(32'(o_card_in_reset), 32'h0);
    half_len();
    check(len, 32'(NORMAL_HALF));
    for (int k = 0; k < CARD_REGS; k++)
      write_word(32'hF000_0000 | 32'(k << CARD_IDX_LSB), 32'h8000_0001 ^ (32'(k) << 28));
    for (int k = 0; k < CARD_REGS; k++)
    begin
      xfer(1'h0, 32'hF000_0000 | 32'(k << CARD_IDX_LSB), '0);
      check(rd, 32'h8000_0001 ^ (32'(k) << 28));
    end
    i_power_mode = PWR_STOP;
    tick(30);
    check(32'(o_clock_full), 32'h0);
    len = '0;
    repeat (20)
    begin
      @(posedge i_clk);
      if (link_if.socket_clock_out !== 1'h0)
        len++;
    end
    check(len, 32'h0);
    #1;
    i_clock_request = 1'h1;
    for (n = 0; n < 20 && o_clock_full !== 1'h1; n++)
      @(posedge i_clk);
    check(32'(o_clock_full), 32'h1);
    #1;
    i_power_mode = PWR_NORMAL;
    tick(1);
    i_clock_request = 1'h0;
    i_power_mode = PWR_SLOW;
    tick(30);
    half_len();
    check(len, 32'(SLOW_HALF));
    write_word(32'h7000_000C, 32'h7FFF_FFFE);
    xfer(1'h0, 32'h7000_000C, '0);
    check(rd, 32'h7FFF_FFFE);
    i_power_mode = PWR_NORMAL;
    i_card_reset = 1'h1;
    tick(6);
    check(32'(o_card_in_reset), 32'h1);
    check(link_if.socket_addr_data, AD_IDLE);
    check(32'(link_if.ad_card_oe), 32'h0);
    i_card_reset = 1'h0;
    tick(12);
    check(o_write_addr, 32'h7000_000C);
    xfer(1'h0, 32'hF000_0004, '0);
    check(rd, 32'h0);
    wrap_up();
  end
endmodule : testbench
